/* lsc_limit_switch.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lsc_consts.svh"
module lsc_limit_switch #(
  parameter int CYC_PER_MS = `LSC_PULSE_UNIT_NS / `LSC_CLK_PERIOD_NS
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire lsc_pkg::lsc_pos_t feedbackPosition,
  input  wire logic             regWr,
  input  wire logic             regRd,
  input  wire logic [15:0]      regAddr,
  input  wire logic [15:0]      regWrData,
  output logic [15:0]           regRdData,
  output logic                  regRdValid,
  output logic [7:0]            switchState
);
  localparam int NSW  = `LSC_NUM_SWITCHES;
  localparam int SUBW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
  localparam logic [SUBW-1:0] SUB_TOP = SUBW'(CYC_PER_MS - 1);

  lsc_pkg::lsc_pos_t trig [NSW];
  logic [7:0]        singleMask;
  logic [7:0]        unitMask;
  logic [7:0]        rearmNow;
  logic [7:0]        done;
  logic [7:0]        prevHit;
  logic [7:0]        hit;
  logic [7:0]        armed;
  logic [7:0]        start;
  logic [7:0]        fire;
  logic [7:0]        next_state;
  logic [7:0]        next_done;
  logic [15:0]       rdReg;
  logic              rdFromMem;

  lsc_mem_if #(.DEPTH(NSW), .W(16)) pulseMem ();
  lsc_word_mem #(.DEPTH(NSW), .W(16), .RESET_VAL(`LSC_PULSE_RESET)) uPulseMem (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .port    (pulseMem)
  );

  // address decode
  wire        selSingle = regAddr == `LSC_ADDR_SINGLE;
  wire        selUnits  = regAddr == `LSC_ADDR_UNITS;
  wire        selRearm  = regAddr == `LSC_ADDR_REARM;
  wire        selState  = regAddr == `LSC_ADDR_STATE;
  wire        selTrig   = regAddr >= `LSC_ADDR_TRIG_FIRST && regAddr <= `LSC_ADDR_TRIG_LAST;
  wire        selPulse  = regAddr >= `LSC_ADDR_PULSE_FIRST && regAddr <= `LSC_ADDR_PULSE_LAST && !regAddr[0];
  wire [15:0] trigOff   = regAddr - `LSC_ADDR_TRIG_FIRST;
  wire [15:0] pulseOff  = regAddr - `LSC_ADDR_PULSE_FIRST;
  wire [2:0]  trigIdx   = trigOff[4:2];
  wire [1:0]  trigWord  = trigOff[1:0];
  wire [2:0]  pulseIdx  = pulseOff[3:1];

  // a trigger point is a 64-bit word group; only the low 32 bits are kept, the top two words mirror the sign
  wire lsc_pkg::lsc_pos_t trigSel = trig[trigIdx];
  wire [15:0] trigRdWord = (trigWord == `LSC_TRIG_WORD_HI) ? trigSel[31:16] :
                           (trigWord == `LSC_TRIG_WORD_LO) ? trigSel[15:0] : {16{trigSel[31]}};
  // the state word decodes but has no write path
  wire [15:0] next_rd = selSingle ? {8'h00, singleMask} :
                        selUnits  ? {8'h00, unitMask} :
                        selState  ? {8'h00, switchState} : // RL4
                        selTrig   ? trigRdWord : 16'h0000;

  assign pulseMem.wrEn   = regWr && selPulse;
  assign pulseMem.wrIdx  = pulseIdx;
  assign pulseMem.wrData = regWrData;
  assign pulseMem.rdIdx  = pulseIdx;
  assign regRdData       = rdFromMem ? pulseMem.rdData : rdReg;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      regRdValid <= 1'b0;
      rdFromMem  <= 1'b0;
      rdReg      <= 16'h0000;
    end
    else
    begin
      regRdValid <= regRd;
      rdFromMem  <= regRd && selPulse;
      rdReg      <= next_rd;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      singleMask <= 8'h00;
      unitMask   <= 8'h00;
      rearmNow   <= 8'h00;
    end
    else
    begin
      if (regWr && selSingle)
        singleMask <= regWrData[7:0];
      if (regWr && selUnits)
        unitMask <= regWrData[7:0];
      // re-arm is a command: it lives for one cycle and reads back as zero
      rearmNow <= (regWr && selRearm) ? regWrData[7:0] : 8'h00; // RL2 RL10
    end
  end

  assign fire      = next_state & ~switchState;
  // a completion in the same cycle as a re-arm still latches
  assign next_done = (singleMask & fire) | (done & ~rearmNow); // RL2 RL3 RL10

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      switchState <= 8'h00;
      done        <= 8'h00;
      prevHit     <= 8'h00;
    end
    else
    begin
      switchState <= next_state; // RL5
      done        <= next_done;
      prevHit     <= hit;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NSW; i++)
    begin : gSw
      logic [15:0]     msLeft;
      logic [SUBW-1:0] sub;
      wire lsc_pkg::lsc_unit_t unitMode = unitMask[i] ? lsc_pkg::LSC_TIMED : lsc_pkg::LSC_POSITION;
      wire subZero  = sub == '0;
      wire lastTick = subZero && msLeft == 16'h0001;

      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
          trig[i] <= '0;
        else if (regWr && selTrig && trigIdx == i && trigWord == `LSC_TRIG_WORD_HI)
          trig[i][31:16] <= regWrData; // RL1
        else if (regWr && selTrig && trigIdx == i && trigWord == `LSC_TRIG_WORD_LO)
          trig[i][15:0] <= regWrData; // RL1
      end

      assign hit[i]   = feedbackPosition >= trig[i]; // RL1 RL8
      assign armed[i] = !singleMask[i] || !done[i]; // RL7
      // a zero pulse time never opens a pulse
      assign start[i] = unitMode == lsc_pkg::LSC_TIMED && hit[i] && !prevHit[i] && armed[i]
                        && pulseMem.entries[i] != 16'h0000; // RL9
      assign next_state[i] = (unitMode == lsc_pkg::LSC_TIMED) ?
                             (start[i] || (switchState[i] && !lastTick)) : // RL9
                             (hit[i] && (switchState[i] || armed[i])); // RL8 RL7

      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          msLeft <= 16'h0000;
          sub    <= '0;
        end
        else if (start[i])
        begin
          msLeft <= pulseMem.entries[i]; // RL9
          sub    <= SUB_TOP;
        end
        else if (switchState[i] && subZero)
        begin
          msLeft <= msLeft - 16'h0001;
          sub    <= SUB_TOP;
        end
        else if (switchState[i])
          sub <= sub - SUBW'(1);
      end

      // helper: measures each timed pulse; counts the edges at which the pulse already stood, so the falling edge is included once
      logic [39:0] hiCnt;
      logic [15:0] ptLatched;
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n || !unitMask[i])
        begin
          hiCnt     <= '0;
          ptLatched <= 16'h0000;
        end
        else if (start[i])
        begin
          hiCnt     <= 40'h0;
          ptLatched <= pulseMem.entries[i];
        end
        else if (switchState[i])
          hiCnt <= hiCnt + 40'h1;
      end

      sequence s_rearm_one;
        regWr && selRearm && regWrData[i];
      endsequence
      sequence s_rearm_zero;
        regWr && selRearm && !regWrData[i];
      endsequence

      chk_pos_active: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL8
        (!unitMask[i] && hit[i] && (switchState[i] || armed[i])) |=> switchState[i])
        else $error("position switch not active at trigger point");
      chk_pos_below: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL8
        (!unitMask[i] && !hit[i]) |=> !switchState[i])
        else $error("position switch active below trigger point");
      chk_timed_start: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL9
        (unitMask[i] && !switchState[i] && hit[i] && !prevHit[i] && armed[i]
         && pulseMem.entries[i] != 16'h0000) |=> switchState[i])
        else $error("timed switch missed its crossing");
      chk_timed_length: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL9
        ($fell(switchState[i]) && unitMask[i] && $past(unitMask[i]))
        |-> hiCnt == 40'(longint'(ptLatched) * longint'(CYC_PER_MS)))
        else $error("timed pulse length wrong");
      chk_single_block: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL7
        (singleMask[i] && done[i] && !rearmNow[i] && !switchState[i]) |=> !switchState[i])
        else $error("single-shot switch fired twice");
      chk_single_latch: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL7
        (singleMask[i] && $rose(switchState[i])) |-> done[i])
        else $error("single-shot completion not latched");
      chk_rearm_clears: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL2
        s_rearm_one ##1 !fire[i] |=> !done[i])
        else $error("re-arm did not clear completion");
      chk_rearm_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL3
        s_rearm_zero ##1 done[i] |=> done[i])
        else $error("zero re-arm bit changed completion");
      chk_rearm_refire: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL10
        (s_rearm_one ##1 !fire[i] ##1 (!unitMask[i] && hit[i] && singleMask[i])) |=> switchState[i])
        else $error("re-armed switch did not fire");
    end
  endgenerate

  chk_state_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL4
    (regRd && selState) |=> (regRdValid && regRdData == {8'h00, $past(switchState)}))
    else $error("state word read back wrong");
  chk_state_ro: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL5
    (regWr && selState) |=> ($stable(singleMask) && $stable(unitMask) && rearmNow == 8'h00))
    else $error("write to state word changed a register");
  chk_trig_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL1
    (regWr && selTrig && trigWord == `LSC_TRIG_WORD_LO) |=> trig[$past(trigIdx)][15:0] == $past(regWrData))
    else $error("trigger point low word not stored");
  chk_pulse_default: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL6
    $rose(rst_n) |-> pulseMem.entries[0] == `LSC_PULSE_RESET)
    else $error("pulse time default wrong");
endmodule
`default_nettype wire

/* lsc_consts.svh */
// Operation
// RL1: each of the eight switches holds its own trigger point, the position at which it fires.
// RL2: writing a one to bit n of the re-arm mask re-arms the single-shot watch of switch n+1; values 0 to 255.
// RL3: a zero bit in the re-arm mask leaves the watch of that switch untouched.
// RL4: the switch state word has bit n set while switch n+1 is active and clear while inactive.
// RL5: the switch state word is read-only; writes to it change nothing and only the compare logic drives it.
// RL6: each switch has a writable pulse time in milliseconds, 0 up to 65,536 ms, defaulting to 500 ms; the 16-bit entries here stop at 65,535 ms.
// RL7: a switch whose single-shot bit is one is watched until it fires once, otherwise it is watched continuously.
// RL8: with unit-select zero a switch is active while the position is at or above its trigger point (zero width).
// RL9: with unit-select one a switch goes active when its trigger point is crossed and stays so for its pulse time.
// RL10: a re-arm acts in the next evaluation cycle and clears the latched single-shot completion of that switch.
`ifndef LSC_CONSTS_SVH
`define LSC_CONSTS_SVH

`define LSC_NUM_SWITCHES    8
`define LSC_ADDR_SINGLE     16'h026c
`define LSC_ADDR_TRIG_FIRST 16'h026e
`define LSC_ADDR_TRIG_LAST  16'h028d
`define LSC_ADDR_REARM      16'h028e
`define LSC_ADDR_STATE      16'h0290
`define LSC_ADDR_PULSE_FIRST 16'h0292
`define LSC_ADDR_PULSE_LAST 16'h02a0
`define LSC_ADDR_UNITS      16'h02a2
`define LSC_TRIG_WORD_HI    2'h2
`define LSC_TRIG_WORD_LO    2'h3
`define LSC_PULSE_RESET     16'h01f4
`define LSC_PULSE_UNIT_NS   1000000
`define LSC_CLK_PERIOD_NS   8

`endif

/* lsc_pkg.sv */
package lsc_pkg;
  typedef logic [15:0]        lsc_word_t;
  typedef logic signed [31:0] lsc_pos_t;
  typedef enum logic {LSC_POSITION, LSC_TIMED} lsc_unit_t;
endpackage

/* lsc_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lsc_mem_if #(parameter int DEPTH = 8, parameter int W = 16);
  logic                     wrEn;
  logic [$clog2(DEPTH)-1:0] wrIdx;
  logic [W-1:0]             wrData;
  logic [$clog2(DEPTH)-1:0] rdIdx;
  logic [W-1:0]             rdData;
  logic [W-1:0]             entries [DEPTH];
  modport mem  (input wrEn, wrIdx, wrData, rdIdx, output rdData, entries);
  modport user (output wrEn, wrIdx, wrData, rdIdx, input rdData, entries);
endinterface
`default_nettype wire

/* lsc_word_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lsc_consts.svh"
module lsc_word_mem #(
  parameter int          DEPTH     = 8,
  parameter int          W         = 16,
  parameter logic [15:0] RESET_VAL = `LSC_PULSE_RESET
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  lsc_mem_if.mem    port
);
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : gEntry
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
          port.entries[g] <= W'(RESET_VAL); // RL6
        else if (port.wrEn && port.wrIdx == g)
          port.entries[g] <= port.wrData; // RL6
      end
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      port.rdData <= '0;
    else
      port.rdData <= port.entries[port.rdIdx];
  end
endmodule
`default_nettype wire

/* lsc_pos_feed.sv */
`timescale 1ns/1ps
`default_nettype none
module lsc_pos_feed (
  input  wire lsc_pkg::lsc_pos_t target,
  input  wire lsc_pkg::lsc_pos_t step,
  input  wire logic              ref_clk,
  output var  lsc_pkg::lsc_pos_t pos
);
  // slews in small steps so every trigger point is crossed, never jumped over in one cycle
  initial pos = '0;
  always @(posedge ref_clk)
  begin
    if (pos + step <= target)
      pos <= #1 pos + step;
    else if (pos - step >= target)
      pos <= #1 pos - step;
    else
      pos <= #1 target;
  end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lsc_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t %h %h", $time, g, e); end end
module tb_top;
  localparam int     CPM = 4;
  logic              ref_clk, rst_n, regWr, regRd, regRdValid, expValid;
  logic [15:0]       regAddr, regWrData, regRdData, expRd, off;
  logic [7:0]        switchState, ss, un, st, done, prevHit, rearm, nst, hit;
  lsc_pkg::lsc_pos_t pos, target, step;
  int                n_mismatch, num_checks, cycles, seed;
  int                trig [8], pt [8], cnt [8];

  lsc_limit_switch #(.CYC_PER_MS(CPM)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .feedbackPosition(pos),
    .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .switchState(switchState));
  lsc_pos_feed u_feed (.ref_clk(ref_clk), .target(target), .step(step), .pos(pos));

  initial
  begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] rdMap(input logic [15:0] a);
    logic [15:0] o;
    logic [15:0] k;
    logic [31:0] t;
    k = a - `LSC_ADDR_TRIG_FIRST;
    t = trig[k[4:2]];
    o = 16'h0000;
    if (a == `LSC_ADDR_SINGLE)
      o = {8'h00, ss};
    else if (a >= `LSC_ADDR_TRIG_FIRST && a <= `LSC_ADDR_TRIG_LAST)
      o = k[1:0] == `LSC_TRIG_WORD_HI ? t[31:16] : k[1:0] == `LSC_TRIG_WORD_LO ? t[15:0] : {16{t[31]}};
    else if (a == `LSC_ADDR_STATE)
      o = {8'h00, st};
    else if (a >= `LSC_ADDR_PULSE_FIRST && a <= `LSC_ADDR_PULSE_LAST && !a[0])
      o = 16'(pt[(a - `LSC_ADDR_PULSE_FIRST) >> 1]);
    else if (a == `LSC_ADDR_UNITS)
      o = {8'h00, un};
    return o;
  endfunction

  // reference model: read answer uses the state from before this edge
  always @(posedge ref_clk)
  begin
    cycles++;
    expValid = rst_n && regRd;
    expRd = rdMap(regAddr);
    if (!rst_n)
    begin
      {ss, un, st, done, prevHit, rearm} = '0;
      foreach (trig[i])
      begin
        trig[i] = 0;
        pt[i] = `LSC_PULSE_RESET;
        cnt[i] = 0;
      end
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        hit[i] = pos >= trig[i];
        if (un[i])
        begin
          if (hit[i] && !prevHit[i] && (!ss[i] || !done[i]) && pt[i] != 0)
            cnt[i] = pt[i] * CPM;
          else if (cnt[i] > 0)
            cnt[i]--;
          nst[i] = cnt[i] > 0;
        end
        else
          nst[i] = hit[i] && (st[i] || !ss[i] || !done[i]);
        done[i] = (nst[i] && !st[i] && ss[i]) || (done[i] && !rearm[i]);
      end
      st = nst;
      prevHit = hit;
      rearm = (regWr && regAddr == `LSC_ADDR_REARM) ? regWrData[7:0] : 8'h00;
      off = regAddr - `LSC_ADDR_TRIG_FIRST;
      if (regWr && regAddr == `LSC_ADDR_SINGLE)
        ss = regWrData[7:0];
      if (regWr && regAddr == `LSC_ADDR_UNITS)
        un = regWrData[7:0];
      if (regWr && regAddr >= `LSC_ADDR_TRIG_FIRST && regAddr <= `LSC_ADDR_TRIG_LAST)
      begin
        if (off[1:0] == `LSC_TRIG_WORD_HI)
          trig[off[4:2]][31:16] = regWrData;
        if (off[1:0] == `LSC_TRIG_WORD_LO)
          trig[off[4:2]][15:0] = regWrData;
      end
      if (regWr && regAddr >= `LSC_ADDR_PULSE_FIRST && regAddr <= `LSC_ADDR_PULSE_LAST && !regAddr[0])
        pt[(regAddr - `LSC_ADDR_PULSE_FIRST) >> 1] = regWrData;
    end
  end

  always @(negedge ref_clk)
  begin
    if (rst_n)
    begin
      `CHK(switchState, st)
      `CHK(regRdValid, expValid)
      if (expValid)
        `CHK(regRdData, expRd)
    end
  end

  always @(posedge ref_clk)
  begin
    if (cycles > 10000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic bus(input logic w, input int a, input int d);
    @(posedge ref_clk);
    #1 {regWr, regRd, regAddr, regWrData} = {w, !w, 16'(a), 16'(d)};
    @(posedge ref_clk);
    #1 {regWr, regRd} = 2'b00;
  endtask

  // rearm values stay within 0..255 on this side
  task automatic go(input int t);
    target = t;
    step = 1 + ($random(seed) & 3);
    repeat (150) @(posedge ref_clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    seed = 33664;
    {regWr, regRd, regAddr, regWrData, rst_n, target, step} = '0;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1;
    // units kept at zero here so every switch stays in position mode and no timed pulse starts during this register sweep
    for (int a = 'h26c; a <= 'h2a4; a++)
      bus(1, a, a == `LSC_ADDR_UNITS ? 0 : a == `LSC_ADDR_REARM ? $random(seed) & 'hff : $random(seed));
    for (int a = 'h26c; a <= 'h2a4; a++)
      bus(0, a, 0);
    #1 rst_n = 0;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1;
    for (int a = 'h26a; a <= 'h2a4; a++)
      bus(0, a, 0);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      bus(1, `LSC_ADDR_TRIG_FIRST + 4 * i + 3, i * 16 + 8 + ($random(seed) & 7));
      bus(1, `LSC_ADDR_PULSE_FIRST + 2 * i, i == 7 ? 0 : 1 + i % 3);
    end
    go(140);
    go(0);
    $display("test position done");
    bus(1, `LSC_ADDR_SINGLE, 'hff);
    go(140);
    go(0);
    go(140);
    bus(1, `LSC_ADDR_REARM, 'haa);
    go(0);
    bus(1, `LSC_ADDR_REARM, 'h55);
    go(140);
    go(0);
    $display("test single shot done");
    bus(1, `LSC_ADDR_SINGLE, 'h0f);
    bus(1, `LSC_ADDR_UNITS, 'hff);
    go(140);
    go(0);
    bus(1, `LSC_ADDR_REARM, 'h0f);
    go(140);
    $display("test timed done");
    report_and_stop();
  end
endmodule
`default_nettype wire
